// ==== src/pct_top.sv ====
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Ten preempt channels; 1-6 high priority, each rail or emergency type.
// - Each high-priority channel has its own input, active when grounded.
// - Channels 1 and 2 take input n from a 0-4 selector; 0 keeps own.
// - After acceptance, time a 0-600 s delay before the sequence proper.
// - Unlocked call dropped during delay abandons the request.
// - Locked call completes minimum duration and dwell despite call loss.
// - Minimum duration 0-9999 s starts at delay end; dwell held until done.
// - Call present beyond maximum presence stops being recognised.
// - Invalidated call stays invalid until the input goes inactive.
// - Maximum presence of zero disables the limit.
// - Accepted preempt holds green for lesser of preempt and phase min green.
// - Accepted preempt holds walk for lesser of preempt min walk and walk.
// - Phase-driven walk stays lit while walk times on the phase.
// - Overlap-driven walk ends at once and goes to ped clearance.
// - High-priority preempt runs free while called or timers run.
// - High-priority preempt lets normally omitted phases be served.
// - Phases in preemption run only with a vehicle call or recall.
// - Locked preempt holds a constant call until minimum periods are met; lost in delay, it drops once delay count >= dur_q and last dw_q >= dwell_q.
// - Dwell lasts at least min dwell 1-255 s and while call present.
module pct_top
    import pct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [PCT_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Cabinet preempt inputs, ground true
    input wire logic [PCT_CH-1:0] preempt_in_n,
    // Controller time base and phase status
    input wire logic sec_tick,
    input wire logic [7:0] phase_min_green,
    input wire logic [7:0] phase_walk,
    input wire logic phase_green,
    input wire logic walk_timing,
    input wire logic ped_overlap_walk_req,
    input wire logic [7:0] phase_demand,
    // Preempt status to the controller
    output logic [PCT_CH-1:0] preempt_call,
    output logic [PCT_CH-1:0] preempt_active,
    output logic run_free,
    output logic allow_omitted,
    output logic [7:0] serve_phase,
    output logic green_hold,
    output logic walk_hold,
    output logic phase_walk_on,
    output logic ped_overlap_walk,
    output logic ped_overlap_clear
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [PCT_CH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
    always_comb
    begin
        // Two late stages must agree, so a one-cycle glitch never counts
        lvl_d = lvl_q;
        for (int k = 0; k < PCT_CH; k++)
            if (s2_q[k] == s3_q[k])
                lvl_d[k] = s3_q[k];
    end
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            lvl_q <= '1;
        end
        else
        begin
            s1_q <= preempt_in_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    // ------------------------------------------------------------
    // Configuration registers and bus slave
    // ------------------------------------------------------------
    logic [PCT_CH-1:0] lock_q, emergency_type_preempt_q, lock_d, emergency_type_preempt_d;
    logic [9:0] delay_q [PCT_CH];
    logic [9:0] delay_d [PCT_CH];
    logic [13:0] dur_q [PCT_CH], pres_q [PCT_CH];
    logic [13:0] dur_d [PCT_CH], pres_d [PCT_CH];
    logic [7:0] dwell_q [PCT_CH], grn_q [PCT_CH], wlk_q [PCT_CH];
    logic [7:0] dwell_d [PCT_CH], grn_d [PCT_CH], wlk_d [PCT_CH];
    logic [2:0] src1_q, src2_q, src1_d, src2_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    pct_state_t st_q [PCT_CH];
    logic [PCT_CH-1:0] inv_q;
    logic [3:0] ch;
    logic wr_go;
    assign ch = avs_address[8:5];
    assign wr_go = avs_write && !wait_q;
    always_comb
    begin
        // Answer one cycle after the request; unmapped reads give zero
        wait_d = !((avs_read || avs_write) && wait_q);
        rdata_d = rdata_q;
        lock_d = lock_q;
        emergency_type_preempt_d = emergency_type_preempt_q;
        delay_d = delay_q;
        dur_d = dur_q;
        pres_d = pres_q;
        dwell_d = dwell_q;
        grn_d = grn_q;
        wlk_d = wlk_q;
        src1_d = src1_q;
        src2_d = src2_q;
        if (avs_read && wait_q)
        begin
            rdata_d = 32'h0000_0000;
            if (avs_address == PCT_A_SRC)
                rdata_d = {25'h0, src2_q, 1'b0, src1_q};
            else if (avs_address == PCT_A_GSTAT)
                rdata_d = {22'h0, preempt_active};
            else if (ch < 4'(PCT_CH))
                unique case (avs_address[4:0])
                    PCT_F_CTRL: rdata_d = {30'h0, emergency_type_preempt_q[ch], lock_q[ch]};
                    PCT_F_DELAY: rdata_d = {22'h0, delay_q[ch]};
                    PCT_F_DUR: rdata_d = {18'h0, dur_q[ch]};
                    PCT_F_PRES: rdata_d = {18'h0, pres_q[ch]};
                    PCT_F_DWELL: rdata_d = {24'h0, dwell_q[ch]};
                    PCT_F_GRN: rdata_d = {24'h0, grn_q[ch]};
                    PCT_F_WLK: rdata_d = {24'h0, wlk_q[ch]};
                    PCT_F_STAT: rdata_d = {27'h0, inv_q[ch], !lvl_q[ch], preempt_call[ch], st_q[ch]};
                    default: rdata_d = 32'h0000_0000;
                endcase
        end
        if (wr_go)
        begin
            if (avs_address == PCT_A_SRC)
            begin
                src1_d = avs_writedata[PCT_B_SRC1 +: 3];
                src2_d = avs_writedata[PCT_B_SRC2 +: 3];
            end
            else if (ch < 4'(PCT_CH))
                unique case (avs_address[4:0])
                    PCT_F_CTRL:
                    begin
                        lock_d[ch] = avs_writedata[PCT_B_LOCK];
                        emergency_type_preempt_d[ch] = avs_writedata[PCT_B_EMERGENCY_TYPE_PREEMPT];
                    end
                    PCT_F_DELAY: delay_d[ch] = avs_writedata[9:0];
                    PCT_F_DUR: dur_d[ch] = avs_writedata[13:0];
                    PCT_F_PRES: pres_d[ch] = avs_writedata[13:0];
                    PCT_F_DWELL: dwell_d[ch] = avs_writedata[7:0];
                    PCT_F_GRN: grn_d[ch] = avs_writedata[7:0];
                    PCT_F_WLK: wlk_d[ch] = avs_writedata[7:0];
                    default: ;
                endcase
        end
    end
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            lock_q <= '0;
            emergency_type_preempt_q <= '0;
            src1_q <= 3'h0;
            src2_q <= 3'h0;
            for (int k = 0; k < PCT_CH; k++)
            begin
                delay_q[k] <= PCT_RST_DELAY;
                dur_q[k] <= PCT_RST_T14;
                pres_q[k] <= PCT_RST_T14;
                dwell_q[k] <= PCT_RST_DWELL;
                grn_q[k] <= PCT_RST_T8;
                wlk_q[k] <= PCT_RST_T8;
            end
        end
        else
        begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            lock_q <= lock_d;
            emergency_type_preempt_q <= emergency_type_preempt_d;
            src1_q <= src1_d;
            src2_q <= src2_d;
            delay_q <= delay_d;
            dur_q <= dur_d;
            pres_q <= pres_d;
            dwell_q <= dwell_d;
            grn_q <= grn_d;
            wlk_q <= wlk_d;
        end
    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    // ------------------------------------------------------------
    // Source routing
    // ------------------------------------------------------------
    logic [PCT_CH-1:0] raw;
    always_comb
    begin
        raw = ~lvl_q;
        // Selector above 4 is treated as default input
        if (src1_q != 3'h0 && src1_q <= 3'h4)
            raw[0] = !lvl_q[src1_q - 3'h1];
        if (src2_q != 3'h0 && src2_q <= 3'h4)
            raw[1] = !lvl_q[src2_q - 3'h1];
    end
    // ------------------------------------------------------------
    // Per-channel sequencer
    // ------------------------------------------------------------
    logic [PCT_CH-1:0] accept, act_d, call_d;
    for (genvar i = 0; i < PCT_CH; i++) begin : g_ch
        pct_state_t st_d;
        logic [13:0] cnt_q, cnt_d, pc_q, pc_d;
        logic [7:0] dw_q, dw_d;
        logic inv_d, call_ok, mins_met;
        always_comb
        begin
            st_d = st_q[i];
            cnt_d = cnt_q;
            dw_d = dw_q;
            pc_d = raw[i] ? pc_q : 14'h0000;
            inv_d = inv_q[i] && raw[i];
            if (raw[i] && !inv_q[i] && sec_tick && pc_q != 14'h3FFF)
                pc_d = pc_q + 14'h0001;
            if (raw[i] && pres_q[i] != 14'h0000 && pc_q >= pres_q[i])
                inv_d = 1'b1;
            call_ok = raw[i] && !inv_q[i];
            mins_met = cnt_q >= dur_q[i] && dw_q >= dwell_q[i];
            accept[i] = st_q[i] == PCT_IDLE && call_ok;
            unique case (st_q[i])
                PCT_IDLE:
                    if (call_ok)
                    begin
                        st_d = PCT_DELAY;
                        cnt_d = 14'h0000;
                    end
                PCT_DELAY:
                    if (!call_ok && !lock_q[i])
                        st_d = PCT_IDLE;
                    else if (cnt_q >= {4'h0, delay_q[i]})
                    begin
                        st_d = PCT_HOLD;
                        cnt_d = 14'h0000;
                        dw_d = 8'h00;
                    end
                    else if (sec_tick)
                        cnt_d = cnt_q + 14'h0001;
                PCT_HOLD:
                begin
                    if (sec_tick && cnt_q != 14'h3FFF)
                        cnt_d = cnt_q + 14'h0001;
                    if (sec_tick && dw_q != 8'hFF)
                        dw_d = dw_q + 8'h01;
                    // Minimums stand regardless of lock once here
                    if (mins_met && !call_ok)
                        st_d = PCT_IDLE;
                end
                default: st_d = PCT_IDLE;
            endcase
            act_d[i] = st_d != PCT_IDLE;
            call_d[i] = call_ok || (lock_q[i] && st_q[i] != PCT_IDLE && !mins_met);
        end
        always_ff @(posedge clk or negedge arst_n)
            if (!arst_n)
            begin
                st_q[i] <= PCT_IDLE;
                cnt_q <= 14'h0000;
                pc_q <= 14'h0000;
                dw_q <= 8'h00;
                inv_q[i] <= 1'b0;
            end
            else
            begin
                st_q[i] <= st_d;
                cnt_q <= cnt_d;
                pc_q <= pc_d;
                dw_q <= dw_d;
                inv_q[i] <= inv_d;
            end
        property p_abort; @(posedge clk) disable iff (!arst_n)
            st_q[i] == PCT_DELAY && !lock_q[i] && !call_ok |=> st_q[i] == PCT_IDLE; endproperty
        a_abort: assert property (p_abort) else $error("unlocked delay did not abort");
        property p_dwell_held; @(posedge clk) disable iff (!arst_n)
            st_q[i] == PCT_HOLD && (call_ok || dw_q < dwell_q[i]) |=> st_q[i] == PCT_HOLD; endproperty
        a_dwell_held: assert property (p_dwell_held) else $error("dwell left early");
        property p_dur_held; @(posedge clk) disable iff (!arst_n)
            st_q[i] == PCT_HOLD && cnt_q < dur_q[i] |=> st_q[i] == PCT_HOLD; endproperty
        a_dur_held: assert property (p_dur_held) else $error("duration left early");
        property p_invalid; @(posedge clk) disable iff (!arst_n)
            inv_q[i] && raw[i] |=> inv_q[i] && !accept[i]; endproperty
        a_invalid: assert property (p_invalid) else $error("invalid call recovered while present");
        property p_nolimit; @(posedge clk) disable iff (!arst_n)
            pres_q[i] == 14'h0000 && !inv_q[i] |=> !inv_q[i]; endproperty
        a_nolimit: assert property (p_nolimit) else $error("call invalidated with limit off");
        property p_lockcall; @(posedge clk) disable iff (!arst_n)
            lock_q[i] && st_q[i] == PCT_HOLD && !mins_met |=> preempt_call[i]; endproperty
        a_lockcall: assert property (p_lockcall) else $error("locked call not held");
    end
    // ------------------------------------------------------------
    // Phase protection and controller outputs
    // ------------------------------------------------------------
    logic [7:0] gcnt_q, gcnt_d, wcnt_q, wcnt_d;
    logic any_d, hp_d;
    always_comb
    begin
        gcnt_d = (sec_tick && gcnt_q != 8'h00) ? gcnt_q - 8'h01 : gcnt_q;
        wcnt_d = (sec_tick && wcnt_q != 8'h00) ? wcnt_q - 8'h01 : wcnt_q;
        // Lowest numbered channel wins a same-cycle acceptance
        for (int k = PCT_CH - 1; k >= 0; k--)
            if (accept[k])
            begin
                gcnt_d = grn_q[k] < phase_min_green ? grn_q[k] : phase_min_green;
                wcnt_d = wlk_q[k] < phase_walk ? wlk_q[k] : phase_walk;
            end
        any_d = |act_d;
        hp_d = |act_d[PCT_HP-1:0];
    end
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            gcnt_q <= 8'h00;
            wcnt_q <= 8'h00;
            preempt_call <= '0;
            preempt_active <= '0;
            run_free <= 1'b0;
            allow_omitted <= 1'b0;
            serve_phase <= 8'h00;
            green_hold <= 1'b0;
            walk_hold <= 1'b0;
            phase_walk_on <= 1'b0;
            ped_overlap_walk <= 1'b0;
            ped_overlap_clear <= 1'b0;
        end
        else
        begin
            gcnt_q <= gcnt_d;
            wcnt_q <= wcnt_d;
            preempt_call <= call_d;
            preempt_active <= act_d;
            run_free <= hp_d;
            allow_omitted <= hp_d;
            serve_phase <= phase_demand & {8{hp_d}};
            green_hold <= phase_green && gcnt_d != 8'h00;
            walk_hold <= walk_timing && wcnt_d != 8'h00;
            phase_walk_on <= walk_timing;
            ped_overlap_walk <= ped_overlap_walk_req && !any_d;
            ped_overlap_clear <= ped_overlap_walk_req && any_d;
        end
    property p_grn; @(posedge clk) disable iff (!arst_n)
        accept[0] |=> gcnt_q == (grn_q[0] < phase_min_green ? grn_q[0] : $past(phase_min_green)); endproperty
    a_grn: assert property (p_grn) else $error("green hold load wrong");
    property p_ovl; @(posedge clk) disable iff (!arst_n)
        ped_overlap_walk_req && |act_d |=> ped_overlap_clear && !ped_overlap_walk; endproperty
    a_ovl: assert property (p_ovl) else $error("overlap walk not cut");
    property p_free; @(posedge clk) disable iff (!arst_n)
        |preempt_active[PCT_HP-1:0] |-> run_free && allow_omitted; endproperty
    a_free: assert property (p_free) else $error("high priority not free");
    property p_sync; @(posedge clk) disable iff (!arst_n)
        !preempt_in_n[0] [*4] |=> !lvl_q[0]; endproperty
    a_sync: assert property (p_sync) else $error("grounded input not seen");
    c_accept: cover property (@(posedge clk) disable iff (!arst_n) accept[0] ##[1:50] st_q[0] == PCT_HOLD);
    c_abort: cover property (@(posedge clk) disable iff (!arst_n) st_q[2] == PCT_DELAY ##1 st_q[2] == PCT_IDLE);
    c_inv: cover property (@(posedge clk) disable iff (!arst_n) $rose(inv_q[3]));
    c_bus: cover property (@(posedge clk) disable iff (!arst_n) avs_read && !avs_waitrequest);
endmodule : pct_top

// ==== src/pct_pkg.sv ====
package pct_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PCT_CH = 10;
    localparam int PCT_HP = 6;
    localparam int PCT_AW = 9;
    // ------------------------------------------------------------
    // Per-channel register block, byte offsets inside 0x20 window
    // ------------------------------------------------------------
    localparam logic [4:0] PCT_F_CTRL = 5'h00;
    localparam logic [4:0] PCT_F_DELAY = 5'h04;
    localparam logic [4:0] PCT_F_DUR = 5'h08;
    localparam logic [4:0] PCT_F_PRES = 5'h0C;
    localparam logic [4:0] PCT_F_DWELL = 5'h10;
    localparam logic [4:0] PCT_F_GRN = 5'h14;
    localparam logic [4:0] PCT_F_WLK = 5'h18;
    localparam logic [4:0] PCT_F_STAT = 5'h1C;
    // ------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------
    localparam logic [8:0] PCT_A_SRC = 9'h140;
    localparam logic [8:0] PCT_A_GSTAT = 9'h144;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PCT_B_LOCK = 0;
    localparam int PCT_B_EMERGENCY_TYPE_PREEMPT = 1;
    localparam int PCT_B_SRC1 = 0;
    localparam int PCT_B_SRC2 = 4;
    localparam int PCT_B_INV = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PCT_RST_DWELL = 8'h01;
    localparam logic [13:0] PCT_RST_T14 = 14'h0000;
    localparam logic [9:0] PCT_RST_DELAY = 10'h000;
    localparam logic [7:0] PCT_RST_T8 = 8'h00;
    // ------------------------------------------------------------
    // Channel sequence states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PCT_IDLE = 2'b00,
        PCT_DELAY = 2'b01,
        PCT_HOLD = 2'b10
    } pct_state_t;
endpackage : pct_pkg

// ==== tb/pct_cabinet.sv ====
`timescale 1ns/1ps
module pct_cabinet
    import pct_pkg::*;
(
    // Clock
    input wire logic clk,
    // Contact closures asked for by the bench
    input wire logic [PCT_CH-1:0] want,
    // Ground-true contacts
    output logic [PCT_CH-1:0] preempt_in_n
);
    // ------------------------------------------------------------
    // Contacts
    // ------------------------------------------------------------
    // Open contact rises to the cabinet pull-up, so idle reads high
    always_ff @(posedge clk)
    begin
        preempt_in_n <= ~want;
    end
endmodule : pct_cabinet

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb
    import pct_pkg::*;
;
    logic clk, arst_n, avs_read, avs_write, avs_waitrequest, sec_tick;
    logic [PCT_AW-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [PCT_CH-1:0] want, preempt_in_n, preempt_call, preempt_active;
    logic phase_green, walk_timing, ped_overlap_walk_req, run_free, allow_omitted;
    logic green_hold, walk_hold, phase_walk_on, ped_overlap_walk, ped_overlap_clear;
    logic [7:0] phase_min_green, phase_walk, phase_demand, serve_phase;
    int error_cnt, n_tests;

    pct_cabinet u_pct_cabinet (.clk, .want, .preempt_in_n);
    pct_top u_pct_top (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .preempt_in_n, .sec_tick, .phase_min_green,
        .phase_walk, .phase_green, .walk_timing, .ped_overlap_walk_req, .phase_demand,
        .preempt_call, .preempt_active, .run_free, .allow_omitted, .serve_phase,
        .green_hold, .walk_hold, .phase_walk_on, .ped_overlap_walk, .ped_overlap_clear);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task finish_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task chb(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask : chb

    function automatic logic [8:0] ra(input int ch, input logic [4:0] f);
        return {4'(ch), f};
    endfunction : ra

    // Request held until an edge that sees waitrequest low
    task bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Values read right after the edge are those the slave saw at it
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'h0 && n < 50);
        rd = avs_readdata;
        if (avs_waitrequest !== 1'h0)
        begin
            error_cnt++;
            finish_test;
        end
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask : bus

    task tick(input int k);
        repeat (k)
        begin
            @(posedge clk);
            sec_tick <= 1'h1;
            @(posedge clk);
            sec_tick <= 1'h0;
            repeat (4) @(posedge clk);
        end
    endtask : tick

    task drive(input logic [PCT_CH-1:0] w);
        @(posedge clk);
        want <= w;
    endtask : drive

    // Bounded wait on call (c=1) or active (c=0) of one channel
    task wt(input logic c, input int ch, input logic v);
        int n;
        n = 0;
        while ((c ? preempt_call[ch] : preempt_active[ch]) !== v && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        chb(c ? "call" : "active", v, c ? preempt_call[ch] : preempt_active[ch]);
        if (n >= 20)
            finish_test;
    endtask : wt

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #600000;
        error_cnt++;
        finish_test;
    end

    initial
    begin
        {arst_n, avs_read, avs_write, sec_tick, phase_green, walk_timing, ped_overlap_walk_req} = '0;
        avs_address = '0;
        avs_writedata = '0;
        want = '0;
        phase_min_green = 8'h05;
        phase_walk = 8'h01;
        phase_demand = 8'h5A;
        error_cnt = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        bus(1'h0, ra(0, PCT_F_DWELL), 32'h0);
        chk("dwell", 32'h1, rd);
        bus(1'h1, 9'h1E0, 32'hFF);
        bus(1'h0, 9'h1E0, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'h1, ra(0, PCT_F_STAT), 32'hFF);
        bus(1'h1, ra(0, PCT_F_DELAY), 32'h3);
        bus(1'h0, ra(0, PCT_F_DELAY), 32'h0);
        chk("delay", 32'h3, rd);
        // Unlocked call lost in delay
        drive(10'h001);
        wt(1'h0, 0, 1'h1);
        chb("run_free", 1'h1, run_free);
        chb("allow_omitted", 1'h1, allow_omitted);
        chk("serve", 32'h5A, {24'h0, serve_phase});
        tick(1);
        drive(10'h000);
        wt(1'h0, 0, 1'h0);
        tick(4);
        chb("active", 1'h0, preempt_active[0]);
        bus(1'h0, ra(0, PCT_F_STAT), 32'h0);
        chk("stat0", 32'h0, rd);
        // Locked call, min duration 3
        bus(1'h1, ra(1, PCT_F_CTRL), 32'h1);
        bus(1'h1, ra(1, PCT_F_DUR), 32'h3);
        drive(10'h002);
        wt(1'h0, 1, 1'h1);
        repeat (4) @(posedge clk);
        want <= 10'h000;
        repeat (10) @(posedge clk);
        bus(1'h0, ra(1, PCT_F_STAT), 32'h0);
        chk("stat1", 32'h6, rd);
        tick(2);
        chb("active", 1'h1, preempt_active[1]);
        chb("call", 1'h1, preempt_call[1]);
        tick(2);
        chb("active", 1'h0, preempt_active[1]);
        chb("call", 1'h0, preempt_call[1]);
        // Presence limit 2 on ch2, none on ch3
        bus(1'h1, ra(2, PCT_F_PRES), 32'h2);
        drive(10'h00C);
        wt(1'h1, 2, 1'h1);
        tick(1);
        chb("call", 1'h1, preempt_call[2]);
        tick(2);
        chb("call", 1'h0, preempt_call[2]);
        tick(2);
        chb("call", 1'h0, preempt_call[2]);
        chb("call", 1'h1, preempt_call[3]);
        bus(1'h0, ra(2, PCT_F_STAT), 32'h0);
        chk("stat2", 32'h18, rd);
        drive(10'h000);
        repeat (10) @(posedge clk);
        want <= 10'h004;
        wt(1'h1, 2, 1'h1);
        drive(10'h000);
        wt(1'h1, 2, 1'h0);
        // Channel 1 source selector, values 0-4
        for (int n = 0; n < 5; n++)
        begin
            bus(1'h1, PCT_A_SRC, 32'(n));
            drive(10'h001 << ((n == 0) ? 0 : n - 1));
            wt(1'h1, 0, 1'h1);
            drive(10'h000);
            wt(1'h1, 0, 1'h0);
        end
        bus(1'h1, PCT_A_SRC, 32'h0);
        tick(4);
        // Protection of green and walk in service
        bus(1'h1, ra(4, PCT_F_GRN), 32'h3);
        bus(1'h1, ra(4, PCT_F_WLK), 32'h2);
        bus(1'h1, ra(4, PCT_F_DELAY), 32'h5);
        @(posedge clk);
        {phase_green, walk_timing, ped_overlap_walk_req} <= 3'h7;
        repeat (4) @(negedge clk);
        chb("ovl_walk", 1'h1, ped_overlap_walk);
        drive(10'h010);
        wt(1'h0, 4, 1'h1);
        repeat (2) @(negedge clk);
        chb("green_hold", 1'h1, green_hold);
        chb("walk_hold", 1'h1, walk_hold);
        chb("ovl_walk", 1'h0, ped_overlap_walk);
        chb("ovl_clear", 1'h1, ped_overlap_clear);
        tick(1);
        chb("walk_hold", 1'h0, walk_hold);
        chb("walk_on", 1'h1, phase_walk_on);
        tick(1);
        chb("green_hold", 1'h1, green_hold);
        tick(1);
        chb("green_hold", 1'h0, green_hold);
        drive(10'h000);
        finish_test;
    end
endmodule : tb
